// ### logic/fpe_map.svh
// constants for the protection element: offsets, resets, timing
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH
// clock period and processing tick, in nanoseconds
`define FPE_CLK_NS       10
`define FPE_TICK_NS      1000000
// register byte offsets
`define FPE_ADDR_W       8
`define FPE_OFF_CTRL     8'h00
`define FPE_OFF_PU_DLY   8'h04
`define FPE_OFF_TRIP_DLY 8'h08
`define FPE_OFF_DO_DLY   8'h0C
`define FPE_OFF_HOLD     8'h10
`define FPE_OFF_STATUS   8'h14
// delay width in bits and reset values
`define FPE_DLY_W        16
`define FPE_CTRL_RST     11'h000
`define FPE_DLY_RST      16'h0000
`define FPE_HOLD_RST     16'h0000
`define FPE_NPH          3
`endif

// ### logic/fpe_pkg.sv
// types shared by the protection element files
package fpe_pkg;
  typedef enum logic [1:0] {
    FM_OFF = 2'h0, FM_ON = 2'h1, FM_ALARM = 2'h2
  } func_mode_e;
  typedef enum logic [1:0] {
    PM_THREE = 2'h0, PM_SINGLE = 2'h1, PM_NOREF = 2'h2
  } phase_mode_e;
  typedef enum logic [2:0] {
    QS_CURRENT = 3'h0, QS_VOLTAGE = 3'h1, QS_POWER = 3'h2,
    QS_PFACTOR = 3'h3, QS_FREQ = 3'h4, QS_BINARY = 3'h5
  } quantity_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_DELAY = 4'b0010,
    ST_PICKED = 4'b0100, ST_DROP = 4'b1000
  } chan_state_e;
  // control register layout, msb first
  typedef struct packed {
    logic        tag_block;
    logic        voltage_loss_block_enable;
    logic        under_dir;
    logic        rms_method_select;
    quantity_e   quantity_select;
    phase_mode_e phase_mode_select;
    func_mode_e  func_mode;
  } ctrl_s;
  // threshold results from the measurement stage
  typedef struct packed {
    logic [2:0] over_fund;
    logic [2:0] over_rms;
    logic       current_low;
    logic       above_bkr_min;
  } meas_s;
  // element delays in ticks
  typedef struct packed {
    logic [15:0] pickup;
    logic [15:0] trip;
    logic [15:0] dropout;
  } dly_s;
endpackage : fpe_pkg

// ### logic/phase_channel.sv
// one phase of pickup, trip delay and dropout timing
`timescale 1ns/1ps
`include "fpe_map.svh"
module phase_channel (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          tick,
  input  wire logic          clr,
  input  wire logic          viol,
  input  wire logic          trip_en,
  input  wire logic          dly_hold,
  input  wire logic          instant,
  input  wire logic          inhibit,
  input  wire fpe_pkg::dly_s dly,
  output logic               pickup,
  output logic               timeout,
  output logic               trip
);
  fpe_pkg::chan_state_e        state_ff, nxt_state;
  logic [`FPE_DLY_W-1:0]       cnt_ff, nxt_cnt, td_ff, nxt_td;
  logic                        to_ff, nxt_to, trip_ff;
  wire                         picked = (state_ff == fpe_pkg::ST_PICKED) ||
                                        (state_ff == fpe_pkg::ST_DROP);
  wire                         td_run = picked && trip_en && !dly_hold;
  wire                         td_done = td_run && (td_ff >= dly.trip);
  wire logic [`FPE_DLY_W-1:0]  cnt_inc = cnt_ff + `FPE_DLY_W'(1);

  // pickup and dropout sequence, stepped on the tick
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      fpe_pkg::ST_IDLE: if (tick && viol) begin
        nxt_cnt   = `FPE_DLY_W'(1);
        nxt_state = (dly.pickup == '0) ? fpe_pkg::ST_PICKED
                                       : fpe_pkg::ST_DELAY;
      end
      fpe_pkg::ST_DELAY: if (tick) begin
        if (!viol) nxt_state = fpe_pkg::ST_IDLE;
        else if (cnt_ff >= dly.pickup) nxt_state = fpe_pkg::ST_PICKED;
        else nxt_cnt = cnt_inc;
      end
      fpe_pkg::ST_PICKED: if (tick && !viol) begin
        nxt_cnt   = `FPE_DLY_W'(1);
        nxt_state = (dly.dropout == '0) ? fpe_pkg::ST_IDLE
                                        : fpe_pkg::ST_DROP;
      end
      fpe_pkg::ST_DROP: if (tick) begin
        if (viol) nxt_state = fpe_pkg::ST_PICKED;
        else if (cnt_ff >= dly.dropout) nxt_state = fpe_pkg::ST_IDLE;
        else nxt_cnt = cnt_inc;
      end
      default: nxt_state = fpe_pkg::ST_IDLE;
    endcase
  end

  // trip delay keeps counting through dropout, held off by delay hold
  assign nxt_td = !td_run ? '0 :
                  (tick && !td_done) ? td_ff + `FPE_DLY_W'(1) : td_ff;
  // timeout only when violation present at expiry
  assign nxt_to = picked && (to_ff || (tick && td_done && viol));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= fpe_pkg::ST_IDLE;
      cnt_ff   <= '0;
      td_ff    <= '0;
      to_ff    <= 1'b0;
      trip_ff  <= 1'b0;
    end else if (clr) begin
      state_ff <= fpe_pkg::ST_IDLE;
      cnt_ff   <= '0;
      td_ff    <= '0;
      to_ff    <= 1'b0;
      trip_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      td_ff    <= nxt_td;
      to_ff    <= nxt_to;
      trip_ff  <= nxt_to && trip_en && !inhibit ||
                  picked && trip_en && instant && !inhibit;
    end
  end

  assign pickup  = picked;
  assign timeout = to_ff;
  assign trip    = trip_ff;

  AST_ALARM_NO_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    !trip_en |=> !trip)
    else $error("trip raised without trip enable");
  AST_INHIBIT_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    inhibit && $stable(inhibit) |=> !trip)
    else $error("trip raised while inhibited");
endmodule : phase_channel

// ### logic/protection_element.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fpe_map.svh"
module protection_element #(
  parameter int TICK_CYCLES = `FPE_TICK_NS / `FPE_CLK_NS,
  parameter int DLY_W       = `FPE_DLY_W
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // measurement stage, same clock
  input  wire fpe_pkg::meas_s         meas,
  input  wire logic                   fuse_failure_flag,
  input  wire logic                   settings_invalid_in,
  input  wire logic                   other_pickup_in,
  input  wire logic                   other_trip_in,
  // binary inputs from pins
  input  wire logic                   block_in,
  input  wire logic                   delay_hold_in,
  input  wire logic                   instant_in,
  input  wire logic                   trip_inhibit_in,
  input  wire logic [`FPE_NPH-1:0]    phase_trip_inhibit,
  input  wire logic                   direct_trip_in,
  input  wire logic                   feeder_transformer_fail_in,
  input  wire logic                   bus_transformer_fail_in,
  // indications
  output logic [`FPE_NPH-1:0]         pickup_phase,
  output logic                        pickup,
  output logic                        timeout,
  output logic                        trip,
  output logic [`FPE_NPH-1:0]         trip_phase,
  output logic                        general_pickup,
  output logic                        general_trip,
  output logic                        bf_start,
  output logic                        bf_active,
  output logic                        invalid_settings
);
  localparam int NPIN = 7 + `FPE_NPH;
  localparam int TW   = $clog2(TICK_CYCLES + 1);

  // two-stage synchroniser for the binary inputs
  logic [NPIN-1:0] pin_meta_ff, pin_sync_ff;
  wire  [NPIN-1:0] pin_raw = {block_in, delay_hold_in, instant_in,
                              trip_inhibit_in, phase_trip_inhibit,
                              direct_trip_in, feeder_transformer_fail_in,
                              bus_transformer_fail_in};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end
  wire              blk_s      = pin_sync_ff[NPIN-1];
  wire              hold_s     = pin_sync_ff[NPIN-2];
  wire              inst_s     = pin_sync_ff[NPIN-3];
  wire              inh_s      = pin_sync_ff[NPIN-4];
  wire [`FPE_NPH-1:0] ph_inh_s = pin_sync_ff[NPIN-5 -: `FPE_NPH];
  wire              dtrip_s    = pin_sync_ff[2];
  wire              feed_s     = pin_sync_ff[1];
  wire              bus_s      = pin_sync_ff[0];

  // processing tick divider
  logic [TW-1:0] tick_cnt_ff;
  logic          tick_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff     <= (tick_cnt_ff == TW'(TICK_CYCLES - 1));
      tick_cnt_ff <= (tick_cnt_ff == TW'(TICK_CYCLES - 1)) ? '0
                     : tick_cnt_ff + TW'(1);
    end
  end

  // registers
  fpe_pkg::ctrl_s    ctrl_ff;
  logic [DLY_W-1:0]  pu_dly_ff, trip_dly_ff, do_dly_ff, hold_dly_ff;
  logic [31:0]       prdata_ff;
  wire [`FPE_ADDR_W-1:0] addr = paddr[`FPE_ADDR_W-1:0];
  wire sel_ctrl = (addr == `FPE_OFF_CTRL);
  wire sel_pu   = (addr == `FPE_OFF_PU_DLY);
  wire sel_td   = (addr == `FPE_OFF_TRIP_DLY);
  wire sel_do   = (addr == `FPE_OFF_DO_DLY);
  wire sel_hold = (addr == `FPE_OFF_HOLD);
  wire sel_st   = (addr == `FPE_OFF_STATUS);
  wire mapped   = (paddr[31:`FPE_ADDR_W] == '0) &&
                  (sel_ctrl | sel_pu | sel_td | sel_do | sel_hold | sel_st);
  wire wr_en    = psel && penable && pwrite && mapped;
  wire setup_rd = psel && !penable && !pwrite;

  // zero wait state; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= fpe_pkg::ctrl_s'(`FPE_CTRL_RST);
      pu_dly_ff   <= DLY_W'(`FPE_DLY_RST);
      trip_dly_ff <= DLY_W'(`FPE_DLY_RST);
      do_dly_ff   <= DLY_W'(`FPE_DLY_RST);
      hold_dly_ff <= DLY_W'(`FPE_HOLD_RST);
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_ff <= fpe_pkg::ctrl_s'(pwdata[$bits(fpe_pkg::ctrl_s)-1:0]);
      if (sel_pu)   pu_dly_ff   <= pwdata[DLY_W-1:0];
      if (sel_td)   trip_dly_ff <= pwdata[DLY_W-1:0];
      if (sel_do)   do_dly_ff   <= pwdata[DLY_W-1:0];
      if (sel_hold) hold_dly_ff <= pwdata[DLY_W-1:0];
    end
  end

  // element state visible to software
  logic [31:0] status_word, rd_mux;
  assign status_word = 32'({invalid_settings, trip, timeout, pickup,
                            pickup_phase});
  assign rd_mux = sel_ctrl ? 32'(ctrl_ff)     :
                  sel_pu   ? 32'(pu_dly_ff)   :
                  sel_td   ? 32'(trip_dly_ff) :
                  sel_do   ? 32'(do_dly_ff)   :
                  sel_hold ? 32'(hold_dly_ff) :
                  sel_st   ? status_word      : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_ff <= 32'h0000_0000;
    else if (setup_rd) prdata_ff <= mapped ? rd_mux : 32'h0000_0000;
  end
  assign prdata = prdata_ff;

  // quantity class decoding, each function used once
  function automatic logic is_volt(input fpe_pkg::quantity_e q);
    is_volt = (q == fpe_pkg::QS_VOLTAGE);
  endfunction : is_volt
  function automatic logic is_power(input fpe_pkg::quantity_e q);
    is_power = (q == fpe_pkg::QS_POWER) || (q == fpe_pkg::QS_PFACTOR);
  endfunction : is_power

  // blocking conditions that clear the element
  wire q_volt   = is_volt(ctrl_ff.quantity_select);
  wire q_power  = is_power(ctrl_ff.quantity_select);
  wire q_cv     = q_volt || (ctrl_ff.quantity_select == fpe_pkg::QS_CURRENT);
  wire vloss    = fuse_failure_flag || feed_s || bus_s;
  wire vloss_blk = q_volt && ctrl_ff.voltage_loss_block_enable && vloss;
  wire pwr_blk  = q_power && meas.current_low;
  wire clr      = blk_s || ctrl_ff.tag_block ||
                  ctrl_ff.func_mode == fpe_pkg::FM_OFF ||
                  settings_invalid_in ||
                  vloss_blk || pwr_blk;
  wire trip_en  = (ctrl_ff.func_mode == fpe_pkg::FM_ON);
  wire three_ph = (ctrl_ff.phase_mode_select == fpe_pkg::PM_THREE);

  // threshold results: method, direction and external trip
  wire [`FPE_NPH-1:0] over = (q_cv && ctrl_ff.rms_method_select)
                             ? meas.over_rms : meas.over_fund;
  wire [`FPE_NPH-1:0] dir_viol = ctrl_ff.under_dir ? ~over : over;
  wire binary_q = (ctrl_ff.quantity_select == fpe_pkg::QS_BINARY);
  wire [`FPE_NPH-1:0] viol = (binary_q ? '0 : dir_viol) |
                             {`FPE_NPH{dtrip_s}};

  // one channel per phase; only the first runs outside three-phase mode
  fpe_pkg::dly_s dly;
  assign dly = '{pickup: 16'(pu_dly_ff), trip: 16'(trip_dly_ff),
                 dropout: 16'(do_dly_ff)};
  logic [`FPE_NPH-1:0] ch_pu, ch_to, ch_trip;
  genvar g;
  generate
    for (g = 0; g < `FPE_NPH; g++) begin : g_ph
      phase_channel u_ch (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick_ff),
        .clr      (clr || (g != 0 && !three_ph)),
        .viol     (viol[g]),
        .trip_en  (trip_en),
        .dly_hold (hold_s),
        .instant  (inst_s),
        .inhibit  (inh_s || ph_inh_s[g]),
        .dly      (dly),
        .pickup   (ch_pu[g]),
        .timeout  (ch_to[g]),
        .trip     (ch_trip[g])
      );
    end
  endgenerate

  // minimum trip hold after the element trip falls
  logic [DLY_W-1:0] hold_cnt_ff, nxt_hold_cnt;
  wire elem_trip = |ch_trip;
  assign nxt_hold_cnt = elem_trip ? hold_dly_ff :
                        (tick_ff && hold_cnt_ff != '0) ?
                        hold_cnt_ff - DLY_W'(1) : hold_cnt_ff;
  wire nxt_trip = elem_trip || (hold_cnt_ff != '0);

  // registered indications
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_ff      <= '0;
      pickup_phase     <= '0;
      pickup           <= 1'b0;
      timeout          <= 1'b0;
      trip             <= 1'b0;
      trip_phase       <= '0;
      general_pickup   <= 1'b0;
      general_trip     <= 1'b0;
      bf_start         <= 1'b0;
      bf_active        <= 1'b0;
      invalid_settings <= 1'b0;
    end else begin
      hold_cnt_ff      <= clr ? '0 : nxt_hold_cnt;
      pickup_phase     <= three_ph ? ch_pu : '0;
      pickup           <= |ch_pu;
      timeout          <= |ch_to;
      trip             <= !clr && nxt_trip;
      trip_phase       <= three_ph ? ch_trip : '0;
      general_pickup   <= |ch_pu || other_pickup_in;
      general_trip     <= (!clr && nxt_trip) || other_trip_in;
      bf_start         <= elem_trip;
      bf_active        <= elem_trip && meas.above_bkr_min;
      invalid_settings <= settings_invalid_in;
    end
  end

  AST_BLOCK_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    blk_s |=> ##1 !pickup && !trip && !timeout)
    else $error("block did not clear indications");
  AST_VLOSS_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    vloss_blk |=> ##1 !pickup)
    else $error("voltage loss did not block");
  AST_POWER_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_blk |=> ##1 pickup_phase == '0 && !pickup)
    else $error("power element not blocked at low current");
  AST_SINGLE_NO_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
    !three_ph |=> pickup_phase == '0)
    else $error("phase indication outside three-phase mode");
  AST_ALARM_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff.func_mode == fpe_pkg::FM_ALARM && $stable(ctrl_ff)
    && hold_cnt_ff == '0 |=> ##1 !bf_start)
    else $error("breaker failure started in alarm mode");
  AST_GENERAL_OR: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pickup) |-> general_pickup)
    else $error("pickup missing from general pickup");
  AST_TRIP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(elem_trip) && hold_dly_ff != '0 && !clr |=> trip[*2])
    else $error("trip not held after dropout");
  AST_INVALID: assert property (@(posedge pclk) disable iff (!presetn)
    settings_invalid_in |=> invalid_settings ##1 !pickup)
    else $error("invalid settings not reported");
  AST_TICK_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    tick_ff |=> !tick_ff)
    else $error("tick longer than one cycle");
endmodule : protection_element

// ### verification/meas_model.sv
// measurement stage and inrush flags on the far side of the element
`timescale 1ns/1ps
module meas_model (
  input  wire logic [2:0]     above,
  input  wire logic [2:0]     above_rms,
  input  wire logic           low_cur,
  input  wire logic           bkr,
  input  wire logic [2:0]     inrush,
  output fpe_pkg::meas_s      meas,
  output logic [2:0]          phase_trip_inhibit
);
  // per-phase threshold results, fundamental and true rms apart
  assign meas = {above, above_rms, low_cur, bkr};
  // inrush flags routed to the per-phase trip inhibits
  assign phase_trip_inhibit = inrush;
endmodule : meas_model

// ### verification/flexible_protection_element_logic_tb_top.sv
// self-checking bench for the protection element
`timescale 1ns/1ps
module flexible_protection_element_logic_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [2:0] above, arms, inrush, pti, pickup_phase, trip_phase;
  logic low_cur, bkr, fuse, inval, opu, otr, blk, dhold, inst, tinh, dtrip;
  logic feed, bvt, k;
  logic pickup, timeout, trip, gpu, gtr, bfs, bfa, invs;
  fpe_pkg::meas_s meas;
  int num_errors, checks;
  meas_model pm (.above(above), .above_rms(arms), .low_cur(low_cur),
    .bkr(bkr),
    .inrush(inrush), .meas(meas), .phase_trip_inhibit(pti));
  protection_element #(.TICK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .fuse_failure_flag(fuse), .settings_invalid_in(inval),
    .other_pickup_in(opu), .other_trip_in(otr), .block_in(blk),
    .delay_hold_in(dhold), .instant_in(inst), .trip_inhibit_in(tinh),
    .phase_trip_inhibit(pti), .direct_trip_in(dtrip),
    .feeder_transformer_fail_in(feed), .bus_transformer_fail_in(bvt),
    .pickup_phase(pickup_phase), .pickup(pickup), .timeout(timeout),
    .trip(trip), .trip_phase(trip_phase), .general_pickup(gpu),
    .general_trip(gtr), .bf_start(bfs), .bf_active(bfa),
    .invalid_settings(invs));
  // clock source
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // one apb transfer: setup, access until pready, then one idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= {24'h000000, a}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    k = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rs(input logic [31:0] e);
    apb(1'b0, 8'h14, 32'h0);
    chk(r, e);
  endtask : rs
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // watchdog
  initial begin
    #30000;
    num_errors++;
    print_verdict;
  end
  // test sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, above, arms, inrush} = '0;
    {low_cur, bkr, fuse, inval, opu, otr, blk, dhold, inst, tinh} = '0;
    {dtrip, feed, bvt} = '0; presetn = 1'b0;
    wt(3); presetn <= 1'b1; wt(1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(r, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(r, 32'h0);
    chk(32'(k), 32'h1);
    apb(1'b1, 8'h04, 32'h3); apb(1'b1, 8'h08, 32'h2);
    apb(1'b1, 8'h0C, 32'h1); apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h00, 32'h1);
    bkr <= 1'b1; above <= 3'b001; wt(2);
    rs(32'h00);
    wt(40); rs(32'h39);
    chk({trip_phase, gpu, gtr, bfs, bfa}, {3'b001, 4'hF});
    above <= 3'b000; wt(12); rs(32'h20);
    wt(20); rs(32'h00);
    above <= 3'b001; wt(40); blk <= 1'b1; wt(6); rs(32'h00);
    blk <= 1'b0; above <= 3'b000; wt(10);
    apb(1'b1, 8'h00, 32'h2); above <= 3'b111; wt(40);
    rs(32'h0F);
    above <= 3'b000; wt(20); apb(1'b1, 8'h00, 32'h5); above <= 3'b001;
    wt(40); rs(32'h38);
    above <= 3'b000; wt(30); apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h08, 32'hFF); inst <= 1'b1; tinh <= 1'b1; above <= 3'b001;
    wt(40); rs(32'h09);
    tinh <= 1'b0; wt(10); rs(32'h29);
    {inst, above} <= '0; wt(30); apb(1'b1, 8'h08, 32'h2);
    inrush <= 3'b010; above <= 3'b011; wt(50);
    chk(trip_phase, 3'b001);
    {inrush, above} <= '0; wt(30); apb(1'b1, 8'h00, 32'h59);
    dtrip <= 1'b1; wt(50); rs(32'h38);
    dtrip <= 1'b0; wt(30); apb(1'b1, 8'h00, 32'h21);
    low_cur <= 1'b1; above <= 3'b001; wt(40); rs(32'h00);
    low_cur <= 1'b0; wt(40); rs(32'h39);
    above <= 3'b111; wt(30); apb(1'b1, 8'h00, 32'h101);
    above <= 3'b110; wt(40); rs(32'h39);
    above <= 3'b000; wt(30); apb(1'b1, 8'h00, 32'h211);
    fuse <= 1'b1; above <= 3'b001; wt(40); rs(32'h00);
    // transformer breaker pins block as the fuse flag does
    feed <= 1'b1; wt(2); fuse <= 1'b0; wt(40); rs(32'h00);
    {feed, bvt} <= 2'b01; wt(40); rs(32'h00);
    bvt <= 1'b0; wt(40); rs(32'h39);
    // delay hold keeps the trip delay from starting
    above <= '0; wt(30); dhold <= 1'b1; above <= 3'b001;
    wt(50); rs(32'h09);
    dhold <= 1'b0; wt(40); rs(32'h39);
    // true rms only for current and voltage, breaker current low
    above <= '0; bkr <= 1'b0; wt(30); apb(1'b1, 8'h00, 32'h81);
    arms <= 3'b100; wt(40); rs(32'h3C);
    chk({bfs, bfa}, 2'b10);
    apb(1'b1, 8'h00, 32'hA1); wt(40); rs(32'h00);
    // zero pickup delay picks up on the first tick
    arms <= '0; apb(1'b1, 8'h04, 32'h0); apb(1'b1, 8'h00, 32'h1);
    above <= 3'b001; wt(7); rs(32'h09);
    apb(1'b1, 8'h00, 32'h401); wt(2); rs(32'h00);
    above <= '0; apb(1'b1, 8'h00, 32'h1);
    {inval, opu, otr} <= 3'b111; wt(6);
    rs(32'h40);
    chk({gpu, gtr}, 2'b11);
    print_verdict;
  end
endmodule : flexible_protection_element_logic_tb_top
